// File: design/ccc_top.sv
// Capture/compare control core with APB register slave
//
// Summary of operation
// - Mode zero turns the unit off and resets its internal state.
// - Mode 0010 toggles compare output on match and sets event flag.
// - Mode 0100 captures on falling edges, 0101 on rising edges.
// - Mode 0111 captures on every sixteenth rising edge.
// - Mode 1000 drives compare output high on match, sets flag.
// - Mode 1010 only sets the flag on match; pin left alone.
// - Mode 1011 sets flag, resets timebase, starts enabled conversion.
// - Duty bits ignored outside PWM; in PWM low byte holds upper eight.
// - Control bits 7-6 unimplemented and read as zero.
// - Qualifying capture event copies full 16-bit timebase count.
// - Each capture sets the event flag; only software clears it.
// - A newer capture overwrites an unread older value.
// - Pin is monitored even when driven as an output.
// - Mode change may raise a false event; software clears flag.
// - Prescaler cleared when off, outside capture, and on reset.
// - Prescale change does not clear prescaler; software zeroes first.
// - Sleep holds an instruction-clocked timebase; external one runs.
// - Second unit's capture pin selectable from two port pins.
`timescale 1ns/100ps
module ccc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic alt_pin_a,
  input wire logic alt_pin_b,
  input wire logic [15:0] capture_timebase,
  input wire logic timebase_ext_clk,
  input wire logic sleep,
  input wire logic adc_enabled,
  output logic timebase_hold,
  output logic timebase_reset,
  output logic adc_start,
  output logic compare_out,
  output logic compare_oe,
  output logic unit_event_flag,
  output logic pwm_active,
  output logic [9:0] pwm_duty
);

  typedef struct packed {
    logic [3:0] mode;
    logic [1:0] duty;
    logic [7:0] cap_lo;
    logic [7:0] cap_hi;
    logic flag;
    logic alt_sel;
    logic pin_a_s1;
    logic pin_a_s2;
    logic pin_b_s1;
    logic pin_b_s2;
    logic cmp_out;
    logic match_q;
    logic tb_rst;
    logic adc_go;
    logic [31:0] rdata;
  } ccc_top_st_t;

  ccc_top_st_t st_q;
  ccc_top_st_t st_d;

  ccc_cap_if cap_if ();

  logic setup;
  logic access;
  logic wr;
  logic mapped;
  logic match_now;
  logic match_evt;
  logic [7:0] ctrl_rd;

  // Both pins are synchronised before the select, so a select change
  // never passes an unsettled pin to the edge detector
  assign cap_if.pin_sync = st_q.alt_sel ? st_q.pin_b_s2 : st_q.pin_a_s2;
  assign cap_if.mode = st_q.mode;

  ccc_edge_presc u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .cap(cap_if.edge_det)
  );

  // APB decode
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite;

  always_comb begin
    mapped = 1'b0;
    unique case (paddr)
      ccc_pkg::CCC_ADDR_CONTROL: mapped = 1'b1;
      ccc_pkg::CCC_ADDR_CAP_LOW: mapped = 1'b1;
      ccc_pkg::CCC_ADDR_CAP_HIGH: mapped = 1'b1;
      ccc_pkg::CCC_ADDR_FLAG: mapped = 1'b1;
      ccc_pkg::CCC_ADDR_PIN_SEL: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Zero wait states; read data staged in the setup cycle
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // Upper control bits are not stored, so they always read zero
  assign ctrl_rd = {2'b00, st_q.duty, st_q.mode};

  // Compare hits on entry to equality only, so a stalled timebase
  // does not fire repeatedly
  assign match_now = (capture_timebase == {st_q.cap_hi, st_q.cap_lo});
  assign match_evt = match_now & ~st_q.match_q;

  always_comb begin
    st_d = st_q;
    st_d.tb_rst = 1'b0;
    st_d.adc_go = 1'b0;
    st_d.match_q = match_now;
    st_d.pin_a_s1 = alt_pin_a;
    st_d.pin_a_s2 = st_q.pin_a_s1;
    st_d.pin_b_s1 = alt_pin_b;
    st_d.pin_b_s2 = st_q.pin_b_s1;

    // Read data
    if (setup) begin
      st_d.rdata = '0;
      unique case (paddr)
        ccc_pkg::CCC_ADDR_CONTROL: begin
          st_d.rdata[ccc_pkg::CCC_CTRL_MSB:0] = ctrl_rd;
        end
        ccc_pkg::CCC_ADDR_CAP_LOW: begin
          st_d.rdata[7:0] = st_q.cap_lo;
        end
        ccc_pkg::CCC_ADDR_CAP_HIGH: begin
          st_d.rdata[7:0] = st_q.cap_hi;
        end
        ccc_pkg::CCC_ADDR_FLAG: begin
          st_d.rdata[ccc_pkg::CCC_FLAG_BIT] = st_q.flag;
        end
        ccc_pkg::CCC_ADDR_PIN_SEL: begin
          st_d.rdata[ccc_pkg::CCC_PIN_SEL_BIT] = st_q.alt_sel;
        end
        default: begin
          st_d.rdata = '0;
        end
      endcase
    end

    // Register writes
    if (wr) begin
      unique case (paddr)
        ccc_pkg::CCC_ADDR_CONTROL: begin
          st_d.mode = pwdata[ccc_pkg::CCC_MODE_MSB:ccc_pkg::CCC_MODE_LSB];
          st_d.duty = pwdata[ccc_pkg::CCC_DUTY_MSB:ccc_pkg::CCC_DUTY_LSB];
        end
        ccc_pkg::CCC_ADDR_CAP_LOW: begin
          st_d.cap_lo = pwdata[7:0];
        end
        ccc_pkg::CCC_ADDR_CAP_HIGH: begin
          st_d.cap_hi = pwdata[7:0];
        end
        ccc_pkg::CCC_ADDR_FLAG: begin
          // Write one clears; software is the only clearer
          if (pwdata[ccc_pkg::CCC_FLAG_BIT]) begin
            st_d.flag = 1'b0;
          end
        end
        ccc_pkg::CCC_ADDR_PIN_SEL: begin
          st_d.alt_sel = pwdata[ccc_pkg::CCC_PIN_SEL_BIT];
        end
        default: begin
          st_d.mode = st_q.mode;
        end
      endcase
    end

    // Off: compare latch forced low, match history held set
    if (st_q.mode == ccc_pkg::CCC_MODE_OFF) begin
      st_d.cmp_out = 1'b0;
      st_d.match_q = 1'b1;
    end

    // Capture takes priority over a same-cycle register write
    if (cap_if.capture) begin
      st_d.cap_lo = capture_timebase[7:0];
      st_d.cap_hi = capture_timebase[15:8];
      st_d.flag = 1'b1;
    end

    // Compare actions
    if (match_evt) begin
      unique case (st_q.mode)
        ccc_pkg::CCC_MODE_CMP_TOGGLE: begin
          st_d.cmp_out = ~st_q.cmp_out;
          st_d.flag = 1'b1;
        end
        ccc_pkg::CCC_MODE_CMP_SET: begin
          st_d.cmp_out = 1'b1;
          st_d.flag = 1'b1;
        end
        ccc_pkg::CCC_MODE_CMP_CLEAR: begin
          st_d.cmp_out = 1'b0;
          st_d.flag = 1'b1;
        end
        ccc_pkg::CCC_MODE_CMP_SOFT: begin
          st_d.flag = 1'b1;
        end
        ccc_pkg::CCC_MODE_CMP_TRIG: begin
          st_d.flag = 1'b1;
          st_d.tb_rst = 1'b1;
          st_d.adc_go = adc_enabled;
        end
        default: begin
          st_d.tb_rst = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.mode <= ccc_pkg::CCC_CTRL_RESET[ccc_pkg::CCC_MODE_MSB:0];
      st_q.duty <=
        ccc_pkg::CCC_CTRL_RESET[ccc_pkg::CCC_DUTY_MSB:ccc_pkg::CCC_DUTY_LSB];
      st_q.cap_lo <= ccc_pkg::CCC_BYTE_RESET;
      st_q.cap_hi <= ccc_pkg::CCC_BYTE_RESET;
      st_q.flag <= 1'b0;
      st_q.alt_sel <= 1'b0;
      st_q.pin_a_s1 <= 1'b0;
      st_q.pin_a_s2 <= 1'b0;
      st_q.pin_b_s1 <= 1'b0;
      st_q.pin_b_s2 <= 1'b0;
      st_q.cmp_out <= 1'b0;
      st_q.match_q <= 1'b1;
      st_q.tb_rst <= 1'b0;
      st_q.adc_go <= 1'b0;
      st_q.rdata <= 32'h0;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.rdata;
  assign unit_event_flag = st_q.flag;
  assign timebase_reset = st_q.tb_rst;
  assign adc_start = st_q.adc_go;
  assign compare_out = st_q.cmp_out;

  // Only output-driving compare modes claim the pin
  assign compare_oe = (st_q.mode == ccc_pkg::CCC_MODE_CMP_TOGGLE) ||
    (st_q.mode == ccc_pkg::CCC_MODE_CMP_SET) ||
    (st_q.mode == ccc_pkg::CCC_MODE_CMP_CLEAR);

  // Duty bits only count in PWM
  assign pwm_active = ccc_pkg::ccc_is_pwm(st_q.mode);
  assign pwm_duty = pwm_active ? {st_q.cap_lo, st_q.duty} : 10'h000;

  // Instruction-clocked timebase freezes in sleep; capture keeps
  // watching the pin either way
  assign timebase_hold = sleep & ~timebase_ext_clk;

endmodule // ccc_top

// File: design/ccc_pkg.sv
// Package of constants and helpers for the capture/compare control block
package ccc_pkg;

  // Register byte addresses on the APB bus
  localparam logic [7:0] CCC_ADDR_CONTROL = 8'h00;
  localparam logic [7:0] CCC_ADDR_CAP_LOW = 8'h04;
  localparam logic [7:0] CCC_ADDR_CAP_HIGH = 8'h08;
  localparam logic [7:0] CCC_ADDR_FLAG = 8'h0c;
  localparam logic [7:0] CCC_ADDR_PIN_SEL = 8'h10;

  // Control register fields
  localparam int CCC_MODE_LSB = 0;
  localparam int CCC_MODE_MSB = 3;
  localparam int CCC_DUTY_LSB = 4;
  localparam int CCC_DUTY_MSB = 5;
  localparam int CCC_CTRL_MSB = 7;
  localparam logic [7:0] CCC_CTRL_RESET = 8'h00;
  localparam logic [7:0] CCC_BYTE_RESET = 8'h00;

  // Flag and pin select register fields
  localparam int CCC_FLAG_BIT = 0;
  localparam int CCC_PIN_SEL_BIT = 0;

  // Mode codes
  localparam logic [3:0] CCC_MODE_OFF = 4'h0;
  localparam logic [3:0] CCC_MODE_CMP_TOGGLE = 4'h2;
  localparam logic [3:0] CCC_MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] CCC_MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] CCC_MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] CCC_MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] CCC_MODE_CMP_SET = 4'h8;
  localparam logic [3:0] CCC_MODE_CMP_CLEAR = 4'h9;
  localparam logic [3:0] CCC_MODE_CMP_SOFT = 4'ha;
  localparam logic [3:0] CCC_MODE_CMP_TRIG = 4'hb;
  localparam logic [1:0] CCC_PWM_TOP = 2'h3;

  // Last prescaler count before a capture fires, then prescaler clear value and step
  localparam logic [3:0] CCC_PRESC4_LAST = 4'h3;
  localparam logic [3:0] CCC_PRESC16_LAST = 4'hf;
  localparam logic [3:0] CCC_PRESC_CLEAR = 4'h0;
  localparam logic [3:0] CCC_PRESC_STEP = 4'h1;

  function automatic logic ccc_is_capture(input logic [3:0] mode);
    ccc_is_capture = (mode >= CCC_MODE_CAP_FALL) &&
      (mode <= CCC_MODE_CAP_RISE16);
  endfunction

  function automatic logic ccc_is_pwm(input logic [3:0] mode);
    ccc_is_pwm = (mode[3:2] == CCC_PWM_TOP);
  endfunction

endpackage

// File: design/ccc_cap_if.sv
// Interface between the control core and the edge prescaler
`timescale 1ns/100ps
interface ccc_cap_if;
  logic [3:0] mode;
  logic pin_sync;
  logic capture;

  modport ctl (
    output mode,
    output pin_sync,
    input capture
  );

  modport edge_det (
    input mode,
    input pin_sync,
    output capture
  );
endinterface

// File: design/ccc_edge_presc.sv
// Edge detector and capture prescaler on the synchronised pin
`timescale 1ns/100ps
module ccc_edge_presc (
  input wire logic pclk,
  input wire logic presetn,
  ccc_cap_if.edge_det cap
);

  typedef struct packed {
    logic prev;
    logic [3:0] cnt;
    logic capture;
  } ccc_presc_st_t;

  ccc_presc_st_t st_q;
  ccc_presc_st_t st_d;

  always_comb begin
    logic rise;
    logic fall;
    rise = 1'b0;
    fall = 1'b0;
    st_d = st_q;
    // Edge history runs in every mode, so an edge near a mode
    // change may still capture
    st_d.prev = cap.pin_sync;
    st_d.capture = 1'b0;
    // Pin is watched whatever its direction
    rise = cap.pin_sync & ~st_q.prev;
    fall = ~cap.pin_sync & st_q.prev;
    // Off or outside capture: prescaler held clear
    if (!ccc_pkg::ccc_is_capture(cap.mode)) begin
      st_d.cnt = ccc_pkg::CCC_PRESC_CLEAR;
    end else begin
      unique case (cap.mode)
        ccc_pkg::CCC_MODE_CAP_FALL: st_d.capture = fall;
        ccc_pkg::CCC_MODE_CAP_RISE: st_d.capture = rise;
        ccc_pkg::CCC_MODE_CAP_RISE4: begin
          // Count not cleared on a prescale change, so an early hit
          // can follow such a change
          if (rise) begin
            if (st_q.cnt >= ccc_pkg::CCC_PRESC4_LAST) begin
              st_d.cnt = ccc_pkg::CCC_PRESC_CLEAR;
              st_d.capture = 1'b1;
            end else begin
              st_d.cnt = st_q.cnt + ccc_pkg::CCC_PRESC_STEP;
            end
          end
        end
        default: begin
          if (rise) begin
            st_d.cnt = st_q.cnt + ccc_pkg::CCC_PRESC_STEP;
            st_d.capture = (st_q.cnt == ccc_pkg::CCC_PRESC16_LAST);
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign cap.capture = st_q.capture;

endmodule // ccc_edge_presc

// File: sim/ccc_asserts.sv
// Port checker for the capture/compare control core
`timescale 1ns/100ps
module ccc_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic sleep,
  input wire logic timebase_ext_clk,
  input wire logic adc_enabled,
  input wire logic timebase_hold,
  input wire logic timebase_reset,
  input wire logic adc_start,
  input wire logic compare_out,
  input wire logic compare_oe,
  input wire logic unit_event_flag,
  input wire logic pwm_active,
  input wire logic [9:0] pwm_duty
);
  // Shadow of mode and duty, rebuilt from bus writes
  logic [5:0] ctl_q;
  logic [3:0] md;
  logic wr, clr;
  assign wr = psel && penable && pwrite;
  assign clr = wr && paddr == 8'h0c && pwdata[0];
  assign md = ctl_q[3:0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctl_q <= 6'h00;
    else if (wr && paddr == 8'h00) ctl_q <= pwdata[5:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  mode_off_a: assert property (
    wr && paddr == 8'h00 && pwdata[3:0] == 4'h0 |-> ##2 !compare_out
  ) else $error("output not cleared");
  out_rise_a: assert property (
    $rose(compare_out) |-> unit_event_flag && $past(md) inside {4'h2, 4'h8}
  ) else $error("bad output rise");
  pin_drive_a: assert property (
    compare_oe == (md inside {4'h2, 4'h8, 4'h9})
  ) else $error("bad output enable");
  duty_bits_a: assert property (
    pwm_active == (md[3:2] == 2'h3) &&
      pwm_duty == (pwm_active ? {pwm_duty[9:2], ctl_q[5:4]} : 10'h000)
  ) else $error("bad duty");
  trig_pulse_a: assert property (
    timebase_reset |-> ($past(md) == 4'hb && unit_event_flag) ##1
      !timebase_reset
  ) else $error("bad timebase reset");
  adc_start_a: assert property (
    adc_start || timebase_reset |->
      adc_start == (timebase_reset && $past(adc_enabled))
  ) else $error("bad conversion start");
  hold_sleep_a: assert property (
    timebase_hold == (sleep && !timebase_ext_clk)
  ) else $error("bad timebase hold");
  flag_sticky_a: assert property (
    $fell(unit_event_flag) |-> $past(clr)
  ) else $error("flag fell by itself");
  cover property ($rose(unit_event_flag) && md[3:2] == 2'h1);
  cover property (adc_start);
  cover property (pwm_active && pwm_duty[1:0] == 2'h3);
endmodule // ccc_asserts

// File: sim/ccc_pin_model.sv
// Far-side event source on the two selectable capture pins
`timescale 1ns/100ps
module ccc_pin_model (
  input wire logic pclk,
  output logic alt_pin_a,
  output logic alt_pin_b
);
  // Cycles per level, well above the two-cycle minimum
  int hold = 5;
  initial begin
    alt_pin_a = 1'b0;
    alt_pin_b = 1'b0;
  end
  task pulse(input logic on_b);
    repeat (2) begin
      if (on_b) alt_pin_b <= ~alt_pin_b;
      else alt_pin_a <= ~alt_pin_a;
      repeat (hold) @(posedge pclk);
    end
  endtask
endmodule // ccc_pin_model

// File: sim/ccp_control_and_capture_bench.sv
// Self-checking bench for the capture/compare control core
`timescale 1ns/100ps
module ccp_control_and_capture_bench;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, sleep, adc_enabled, pready;
  logic timebase_ext_clk, pslverr, alt_pin_a, alt_pin_b, adc_start;
  logic timebase_hold, timebase_reset, compare_out, compare_oe;
  logic unit_event_flag, pwm_active;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [9:0] pwm_duty;
  logic [15:0] capture_timebase, t1, t2, v;
  logic [32:0] exp_q [$];
  logic [3:0] om [5] = '{4'h8, 4'h9, 4'h2, 4'ha, 4'hb};
  logic [4:0] ov = 5'b11101;
  int cnt [4] = '{1, 2, 4, 16};
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  int seed = 32'h33f3dddb;
  ccc_top dut_u (.*);
  ccc_pin_model pin_u (.*);
  always #20 pclk = ~pclk;
  task end_of_test;
    if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task check(input logic [32:0] s, input logic [32:0] x);
    checked++;
    if (s !== x) begin
      failures++;
      $display("FAIL %0t seen %h want %h", $time, s, x);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] x);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exp_q.push_back(x);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, {1'b0, x});
  endtask
  // Count is a at the rising pin edge and moves to b at the falling one, so edge choice shows
  task pulse(input logic [15:0] a, input logic [15:0] b);
    capture_timebase <= a;
    fork
      pin_u.pulse(1'b0);
      begin
        repeat (5) @(posedge pclk);
        capture_timebase <= b;
      end
    join
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (psel && penable && pready && !pwrite)
      check({pslverr, prdata}, exp_q.pop_front());
    if (cyc == 20000) begin
      failures++;
      end_of_test;
    end
  end
  initial begin
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    sleep <= 1'b0;
    adc_enabled <= 1'b0;
    timebase_ext_clk <= 1'b0;
    capture_timebase <= 16'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 32'h0);
    for (int k = 0; k < 4; k++) begin
      wr(8'h00, 32'h0);
      wr(8'h00, {24'h0, 4'hf, 4'(k + 4)});
      wr(8'h0c, 32'h1);
      rd(8'h00, {26'h0, 2'h3, 4'(k + 4)});
      for (int i = 1; i <= cnt[k]; i++) begin
        t1 = 16'($random(seed));
        t2 = 16'($random(seed));
        pulse(t1, t2);
        if (k > 1 && i == cnt[k] - 1) rd(8'h0c, 32'h0);
      end
      v = (k == 0) ? t2 : t1;
      rd(8'h0c, 32'h1);
      rd(8'h04, {24'h0, v[7:0]});
      rd(8'h08, {24'h0, v[15:8]});
    end
    wr(8'h00, 32'h6);
    repeat (2) pulse(t1, t1);
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h6);
    wr(8'h0c, 32'h1);
    repeat (3) pulse(t1, t1);
    rd(8'h0c, 32'h0);
    wr(8'h00, 32'h5);
    wr(8'h10, 32'h1);
    wr(8'h0c, 32'h1);
    pin_u.pulse(1'b0);
    rd(8'h0c, 32'h0);
    pin_u.pulse(1'b1);
    rd(8'h0c, 32'h1);
    v = 16'($random(seed));
    capture_timebase <= v + 16'h1;
    wr(8'h00, 32'h0);
    wr(8'h04, {24'h0, v[7:0]});
    wr(8'h08, {24'h0, v[15:8]});
    for (int k = 0; k < 5; k++) begin
      wr(8'h00, {28'h0, om[k]});
      wr(8'h0c, 32'h1);
      adc_enabled <= (k == 4);
      capture_timebase <= v;
      @(posedge pclk);
      capture_timebase <= v + 16'h1;
      repeat (3) @(posedge pclk);
      check({32'h0, compare_out}, {32'h0, ov[k]});
      rd(8'h0c, 32'h1);
    end
    wr(8'h00, 32'hfd);
    rd(8'h00, 32'h3d);
    @(posedge pclk);
    check({23'h0, pwm_duty}, {23'h0, v[7:0], 2'h3});
    apb(1'b0, 8'h14, 32'h0, {1'b1, 32'h0});
    repeat (8) begin
      @(posedge pclk);
      sleep <= 1'($random(seed));
      timebase_ext_clk <= 1'($random(seed));
    end
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h0c, 32'h0);
    end_of_test;
  end
endmodule // ccp_control_and_capture_bench
bind ccc_top ccc_asserts chk_u (.*);
